// file: rtl/ihd_top.sv
// integer hardware divider: register slave, iterative divide, interrupt
`timescale 1ns/1ps
`default_nettype none

module ihd_top (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // register port
   input  wire ihd_pkg::ihd_bus_req_s bus_req,
   output var  ihd_pkg::ihd_word_t    bus_rdata,
   // interrupt
   output logic                       irq
);
   import ihd_pkg::*;

   ihd_state_s st_ff;
   ihd_state_s nxt_st;

   logic start_div;
   logic wr_dividend;
   logic wr_sign;
   logic wr_quot;
   logic wr_rem;
   logic wr_istat;
   logic wr_imask;

   assign start_div   = bus_req.wr && (bus_req.addr == IHD_OFF_DIVISOR);
   assign wr_dividend = bus_req.wr && (bus_req.addr == IHD_OFF_DIVIDEND);
   assign wr_sign     = bus_req.wr && (bus_req.addr == IHD_OFF_SIGN);
   assign wr_quot     = bus_req.wr && (bus_req.addr == IHD_OFF_QUOT);
   assign wr_rem      = bus_req.wr && (bus_req.addr == IHD_OFF_REM);
   assign wr_istat    = bus_req.wr && (bus_req.addr == IHD_OFF_IRQ_STAT);
   assign wr_imask    = bus_req.wr && (bus_req.addr == IHD_OFF_IRQ_MASK);

   // magnitude of an operand, signed view only when signed mode is on
   function automatic ihd_word_t ihd_mag(input ihd_word_t v,
                                         input logic sgn);
      ihd_mag = (sgn && v[IHD_WIDTH-1]) ? (~v + 32'h0000_0001) : v;
   endfunction

   always_comb begin
      logic [IHD_WIDTH:0] r;
      ihd_word_t          q;
      logic               neg_q;
      logic               neg_r;
      r      = '0;
      q      = '0;
      neg_q  = 1'b0;
      neg_r  = 1'b0;
      nxt_st = st_ff;

      // read data valid in the cycle after the strobe only
      nxt_st.rdata = '0;
      if (bus_req.rd) begin
         case (bus_req.addr)
            IHD_OFF_DIVIDEND: nxt_st.rdata = st_ff.dividend;
            IHD_OFF_DIVISOR:  nxt_st.rdata = st_ff.divisor;
            IHD_OFF_QUOT:     nxt_st.rdata = st_ff.quot;
            IHD_OFF_REM:      nxt_st.rdata = st_ff.rem;
            IHD_OFF_SIGN: begin
               nxt_st.rdata[IHD_BIT_SIGN] = st_ff.sign_sel;
            end
            IHD_OFF_STATUS: begin
               nxt_st.rdata[IHD_BIT_DONE] = st_ff.done;
               nxt_st.rdata[IHD_BIT_ZERO] = st_ff.zero;
            end
            IHD_OFF_IRQ_STAT: begin
               nxt_st.rdata[IHD_NUM_EVT-1:0] = st_ff.ist;
            end
            IHD_OFF_IRQ_MASK: begin
               nxt_st.rdata[IHD_NUM_EVT-1:0] = st_ff.imask;
            end
            default: nxt_st.rdata = '0;
         endcase
      end

      // plain register writes
      if (wr_dividend) begin
         nxt_st.dividend = bus_req.wdata;
      end
      if (wr_sign) begin
         nxt_st.sign_sel = bus_req.wdata[IHD_BIT_SIGN];
      end
      // results may be preset by software, but not under a running divide
      if (wr_quot && !st_ff.busy) begin
         nxt_st.quot = bus_req.wdata;
      end
      if (wr_rem && !st_ff.busy) begin
         nxt_st.rem = bus_req.wdata;
      end
      if (wr_imask) begin
         nxt_st.imask = bus_req.wdata[IHD_NUM_EVT-1:0];
      end
      // write one to clear; sets below come later and so win
      if (wr_istat) begin
         nxt_st.ist = st_ff.ist & ~bus_req.wdata[IHD_NUM_EVT-1:0];
      end

      // restoring division, four quotient bits per clock
      if (st_ff.busy) begin
         r = st_ff.wr;
         q = st_ff.wq;
         for (int i = 0; i < IHD_BITS_STEP; i++) begin
            r = {r[IHD_WIDTH-1:0], q[IHD_WIDTH-1]};
            q = {q[IHD_WIDTH-2:0], 1'b0};
            if (r >= {1'b0, st_ff.wd}) begin
               r    = r - {1'b0, st_ff.wd};
               q[0] = 1'b1;
            end
         end
         nxt_st.wr  = r;
         nxt_st.wq  = q;
         nxt_st.cnt = st_ff.cnt + 3'h1;
         // truncation toward zero: fix signs of the magnitudes
         neg_q = st_ff.op_sign &&
                 (st_ff.op_a[IHD_WIDTH-1] ^ st_ff.op_b[IHD_WIDTH-1]);
         neg_r = st_ff.op_sign && st_ff.op_a[IHD_WIDTH-1];
         if (st_ff.cnt == IHD_CNT_LAST) begin
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
            nxt_st.quot = neg_q ? (~q + 32'h0000_0001) : q;
            nxt_st.rem  = neg_r ? (~r[IHD_WIDTH-1:0] + 32'h0000_0001)
                                : r[IHD_WIDTH-1:0];
            nxt_st.ist[IHD_BIT_DONE] = 1'b1;
         end
      end

      // a divisor write restarts the unit even mid-division
      if (start_div) begin
         nxt_st.divisor = bus_req.wdata;
         nxt_st.op_a    = st_ff.dividend;
         nxt_st.op_b    = bus_req.wdata;
         nxt_st.op_sign = st_ff.sign_sel;
         nxt_st.done    = 1'b0;
         nxt_st.zero    = 1'b0;
         nxt_st.cnt     = '0;
         if (bus_req.wdata == IHD_RST_ZERO) begin
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
            nxt_st.zero = 1'b1;
            nxt_st.quot = IHD_RST_ZERO;
            nxt_st.rem  = IHD_RST_ZERO;
            nxt_st.ist  = nxt_st.ist | {IHD_NUM_EVT{1'b1}};
         end else begin
            nxt_st.busy = 1'b1;
            nxt_st.wr   = '0;
            nxt_st.wq   = ihd_mag(st_ff.dividend, st_ff.sign_sel);
            nxt_st.wd   = ihd_mag(bus_req.wdata, st_ff.sign_sel);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff         <= '0;
         st_ff.divisor <= IHD_RST_DIVISOR;
         st_ff.quot    <= IHD_RST_ZERO;
         st_ff.rem     <= IHD_RST_ZERO;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bus_rdata = st_ff.rdata;
   // level interrupt, high while any unmasked event is pending
   assign irq = |(st_ff.ist & st_ff.imask);

   // checks
   logic [63:0] chk_prod;
   assign chk_prod = 64'(st_ff.quot) * 64'(st_ff.op_b) + 64'(st_ff.rem);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_start_nz;
      start_div && (bus_req.wdata != IHD_RST_ZERO);
   endsequence

   AST_RESET_VALUES: assert property (
      $past(rst) |-> (st_ff.divisor == IHD_RST_DIVISOR) &&
         (st_ff.rem == IHD_RST_ZERO) && (st_ff.quot == IHD_RST_ZERO) &&
         !st_ff.done && !st_ff.zero && !st_ff.sign_sel)
      else $error("register values wrong after reset");

   AST_DIVISOR_STORED: assert property (
      start_div |=> (st_ff.divisor == $past(bus_req.wdata)) &&
         (st_ff.op_b == $past(bus_req.wdata)))
      else $error("divisor write not stored");

   AST_DIVIDEND_USED: assert property (
      start_div |=> st_ff.op_a == $past(st_ff.dividend))
      else $error("division did not take the stored dividend");

   AST_SIGN_SELECT: assert property (
      wr_sign |=> st_ff.sign_sel == $past(bus_req.wdata[IHD_BIT_SIGN]))
      else $error("signedness bit not written");

   AST_DONE_AFTER_8: assert property (
      s_start_nz ##1 (!start_div)[*8] |=> st_ff.done && !st_ff.busy)
      else $error("division did not finish after 8 cycles");

   AST_CLEAR_ON_START: assert property (
      s_start_nz |=> (!st_ff.done && !st_ff.zero)[*8])
      else $error("flags not held clear while dividing");

   AST_ZERO_DIVISOR: assert property (
      start_div && (bus_req.wdata == IHD_RST_ZERO) |=> st_ff.done &&
         st_ff.zero && (st_ff.quot == IHD_RST_ZERO) &&
         (st_ff.rem == IHD_RST_ZERO))
      else $error("zero divisor not finished at once");

   AST_RESULT_STABLE: assert property (
      st_ff.busy && (st_ff.cnt != IHD_CNT_LAST) |=>
         $stable(st_ff.quot) && $stable(st_ff.rem))
      else $error("result changed while dividing");

   AST_UNSIGNED_RESULT: assert property (
      $rose(st_ff.done) && !st_ff.zero && !st_ff.op_sign |->
         (chk_prod == 64'(st_ff.op_a)) && (st_ff.rem < st_ff.op_b))
      else $error("unsigned quotient or remainder wrong");

   AST_SIGNED_REM: assert property (
      $rose(st_ff.done) && !st_ff.zero && st_ff.op_sign |->
         (st_ff.rem == IHD_RST_ZERO) ||
         (st_ff.rem[IHD_WIDTH-1] == st_ff.op_a[IHD_WIDTH-1]))
      else $error("signed remainder has wrong sign");

   // quot * divisor + rem gives back the dividend modulo 2^32, for the
   // signed and the unsigned view alike, so one check covers both
   AST_REM_WRITTEN: assert property (
      st_ff.busy && (st_ff.cnt == IHD_CNT_LAST) && !start_div |=>
         chk_prod[IHD_WIDTH-1:0] == st_ff.op_a)
      else $error("remainder not loaded at completion");

   AST_STATUS_READ: assert property (
      bus_req.rd && (bus_req.addr == IHD_OFF_STATUS) |=>
         bus_rdata == {30'h0, $past(st_ff.zero), $past(st_ff.done)})
      else $error("status read wrong");

   AST_DONE_EVENT: assert property (
      $rose(st_ff.done) |-> st_ff.ist[IHD_BIT_DONE])
      else $error("done event not latched");

   // cycle count since the last start, kept apart from the divider's own
   // counter so a wrong end point there cannot hide; saturates when idle
   logic [3:0] chk_age_ff;
   logic [3:0] nxt_chk_age;

   always_comb begin
      nxt_chk_age = chk_age_ff;
      if (start_div) begin
         nxt_chk_age = '0;
      end else if (chk_age_ff != 4'hf) begin
         nxt_chk_age = chk_age_ff + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         chk_age_ff <= 4'hf;
      end else begin
         chk_age_ff <= nxt_chk_age;
      end
   end

   AST_LATENCY_COUNT: assert property (
      $rose(st_ff.done) && !st_ff.zero |->
         chk_age_ff == 4'(IHD_DIV_CYCLES))
      else $error("division latency is not 8 cycles");

   AST_BUSY_BOUND: assert property (
      st_ff.busy |-> chk_age_ff < 4'(IHD_DIV_CYCLES))
      else $error("division still busy after 8 cycles");

   AST_RESULT_WRITE_HELD: assert property (
      (wr_quot || wr_rem) && st_ff.busy &&
         (st_ff.cnt != IHD_CNT_LAST) |=>
         $stable(st_ff.quot) && $stable(st_ff.rem))
      else $error("result overwritten while dividing");

   AST_READ_ONE_CYCLE: assert property (
      !bus_req.rd |=> bus_rdata == IHD_RST_ZERO)
      else $error("read data not cleared after one cycle");

   // status is read-only: a write there while no division runs must leave both flags alone
   AST_STATUS_RO: assert property (
      bus_req.wr && (bus_req.addr == IHD_OFF_STATUS) && !st_ff.busy |=>
         $stable(st_ff.done) && $stable(st_ff.zero))
      else $error("status flags changed by a write");

   AST_ZERO_FLAG_NZ: assert property (
      s_start_nz ##1 (!start_div)[*8] |=> !st_ff.zero)
      else $error("zero flag set for a nonzero divisor");

   AST_ZERO_EVENT: assert property (
      start_div && (bus_req.wdata == IHD_RST_ZERO) |=>
         st_ff.ist == {IHD_NUM_EVT{1'b1}})
      else $error("zero divisor events not latched");

   // clear and completion in one cycle: the new event must survive
   AST_SET_WINS: assert property (
      wr_istat && bus_req.wdata[IHD_BIT_DONE] && st_ff.busy &&
         (st_ff.cnt == IHD_CNT_LAST) |=> st_ff.ist[IHD_BIT_DONE])
      else $error("done event lost to a clear");

   AST_DIVIDEND_HELD: assert property (
      st_ff.busy && wr_dividend |=> $stable(st_ff.op_a))
      else $error("running division took a late dividend");

   AST_SIGN_HELD: assert property (
      st_ff.busy && wr_sign |=> $stable(st_ff.op_sign))
      else $error("running division took a late sign setting");

   // magnitude of the remainder stays below that of the divisor
   AST_SIGNED_REM_BOUND: assert property (
      $rose(st_ff.done) && !st_ff.zero && st_ff.op_sign |->
         ihd_mag(st_ff.rem, 1'b1) < ihd_mag(st_ff.op_b, 1'b1))
      else $error("signed remainder too large");

   COV_UNSIGNED: cover property (
      $rose(st_ff.done) && !st_ff.zero && !st_ff.op_sign);
   COV_SIGNED_NEG: cover property (
      $rose(st_ff.done) && st_ff.op_sign && st_ff.quot[IHD_WIDTH-1]);
   COV_ZERO_DIV: cover property (
      start_div && (bus_req.wdata == IHD_RST_ZERO));
   COV_RESTART: cover property (st_ff.busy && start_div);
   COV_IRQ: cover property ($rose(irq));

endmodule

`default_nettype wire

// file: include/ihd_pkg.sv
// package for the integer hardware divider: register map, fields, state
//
// Functional notes
// - each write to divisor_value stores it and starts a new division from the stored dividend and sign setting.
// - divisor_value resets to one so an unloaded divisor cannot divide by zero.
// - quotient_result takes the quotient of every completed division and resets to zero.
// - remainder_result takes the remainder of every completed division.
// - remainder_result reads zero after reset until a division completes; the code also lets software preset it while no division runs.
// - bit 0 of signedness_select picks unsigned (0) or two's-complement signed (1) and resets to 0.
// - status bit 1 is read-only, set when the latest division had a zero divisor, reset 0.
// - status bit 0 is read-only, 0 while a division runs and 1 once the result is ready, reset 0.
// - a division with a nonzero divisor completes 8 clock cycles after it starts.
// - a zero divisor finishes at once with zero quotient and remainder, zero flag and done flag set.
// - quotient and remainder keep the previous results while a division runs.
// - software loads the dividend register first; the division uses that stored dividend.
package ihd_pkg;

   typedef logic [31:0] ihd_word_t;
   typedef logic [7:0]  ihd_addr_t;

   // register byte offsets
   localparam ihd_addr_t IHD_OFF_DIVIDEND = 8'h00;
   localparam ihd_addr_t IHD_OFF_DIVISOR  = 8'h04;
   localparam ihd_addr_t IHD_OFF_QUOT     = 8'h08;
   localparam ihd_addr_t IHD_OFF_REM      = 8'h0c;
   localparam ihd_addr_t IHD_OFF_SIGN     = 8'h10;
   localparam ihd_addr_t IHD_OFF_STATUS   = 8'h14;
   localparam ihd_addr_t IHD_OFF_IRQ_STAT = 8'h18;
   localparam ihd_addr_t IHD_OFF_IRQ_MASK = 8'h1c;

   // reset values
   localparam ihd_word_t IHD_RST_DIVISOR  = 32'h0000_0001;
   localparam ihd_word_t IHD_RST_ZERO     = 32'h0000_0000;

   // field positions: done and zero shared by status and interrupt registers, plus the sign bit
   localparam int IHD_BIT_DONE = 0;
   localparam int IHD_BIT_ZERO = 1;
   localparam int IHD_BIT_SIGN = 0;
   localparam int IHD_NUM_EVT  = 2;

   // iteration timing: 32 quotient bits, 4 per clock, 8 clocks
   localparam int IHD_WIDTH       = 32;
   localparam int IHD_DIV_CYCLES  = 8;
   localparam int IHD_BITS_STEP   = IHD_WIDTH / IHD_DIV_CYCLES;
   localparam logic [2:0] IHD_CNT_LAST = 3'(IHD_DIV_CYCLES - 1);

   typedef struct packed {
      ihd_addr_t addr;
      ihd_word_t wdata;
      logic      wr;
      logic      rd;
   } ihd_bus_req_s;

   typedef struct packed {
      ihd_word_t               dividend;
      ihd_word_t               divisor;
      ihd_word_t               quot;
      ihd_word_t               rem;
      logic                    sign_sel;
      logic                    done;
      logic                    zero;
      logic [IHD_NUM_EVT-1:0]  ist;
      logic [IHD_NUM_EVT-1:0]  imask;
      logic                    busy;
      logic [2:0]              cnt;
      ihd_word_t               wq;
      logic [IHD_WIDTH:0]      wr;
      ihd_word_t               wd;
      ihd_word_t               op_a;
      ihd_word_t               op_b;
      logic                    op_sign;
      ihd_word_t               rdata;
   } ihd_state_s;

endpackage

// file: verif/test_integer_hw_divider.sv
// self-checking bench for the integer hardware divider
`timescale 1ns/1ps
`default_nettype none

module test_integer_hw_divider;
   import ihd_pkg::*;

   typedef struct packed {
      logic      sg;
      ihd_word_t a;
      ihd_word_t b;
      ihd_word_t q;
      ihd_word_t r;
   } ihd_row_s;

   logic         clk;
   logic         rst;
   ihd_bus_req_s bus_req;
   ihd_word_t    bus_rdata;
   logic         irq;
   int           mismatches;
   int           n_compared;
   int           cycles;
   ihd_word_t    v;
   ihd_row_s     rows [8];
   ihd_addr_t    ra [9];
   ihd_word_t    rx [9];

   ihd_top i_ihd_top (
      .clk       (clk),
      .rst       (rst),
      .bus_req   (bus_req),
      .bus_rdata (bus_rdata),
      .irq       (irq)
   );

   always #25 clk = ~clk;

   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input ihd_word_t seen, input ihd_word_t exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // every bus cycle is one edge; a write leaves its strobe up until the
   // next call, so each write must be followed by another bus cycle
   task automatic cyc(input ihd_addr_t a, input ihd_word_t d,
                      input logic w, input logic r);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
   endtask

   task automatic wr(input ihd_addr_t a, input ihd_word_t d);
      cyc(a, d, 1'b1, 1'b0);
   endtask

   task automatic idle;
      cyc('0, '0, 1'b0, 1'b0);
   endtask

   task automatic rd(input ihd_addr_t a, output ihd_word_t d);
      cyc(a, '0, 1'b0, 1'b1);
      @(posedge clk);
      bus_req <= '0;
      #1;
      d = bus_rdata;
   endtask

   task automatic rdc(input ihd_addr_t a, input ihd_word_t e);
      rd(a, v);
      check(v, e);
   endtask

   task automatic wait_done;
      for (int i = 0; i < 20; i++) begin
         rd(IHD_OFF_STATUS, v);
         if (v[IHD_BIT_DONE] === 1'b1) return;
      end
      mismatches++;
   endtask

   task automatic do_reset;
      @(posedge clk);
      rst <= 1'b1;
      bus_req <= '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         give_verdict();
      end
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      bus_req = '0;
      mismatches = 0;
      n_compared = 0;
      cycles = 0;
      rows[0] = '{1'b0, 32'h7250a3fb, 32'h0000257d, 32'h00030ca2, 32'h00000ee1};
      rows[1] = '{1'b1, 32'hfffffff9, 32'h00000002, 32'hfffffffd, 32'hffffffff};
      rows[2] = '{1'b1, 32'h00000007, 32'hfffffffe, 32'hfffffffd, 32'h00000001};
      rows[3] = '{1'b1, 32'h80000000, 32'hffffffff, 32'h80000000, 32'h00000000};
      rows[4] = '{1'b0, 32'hffffffff, 32'h00000001, 32'hffffffff, 32'h00000000};
      rows[5] = '{1'b0, 32'h00000005, 32'h00000000, 32'h00000000, 32'h00000000};
      rows[6] = '{1'b0, 32'h80000000, 32'hffffffff, 32'h00000000, 32'h80000000};
      rows[7] = '{1'b1, 32'hfffffff9, 32'hfffffffe, 32'h00000003, 32'hffffffff};
      ra = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
      rx = '{1: 32'h1, default: 32'h0};
      do_reset();
      foreach (rows[k]) begin
         wr(IHD_OFF_SIGN, {31'h0, rows[k].sg});
         wr(IHD_OFF_DIVIDEND, rows[k].a);
         wr(IHD_OFF_DIVISOR, rows[k].b);
         wait_done();
         rdc(IHD_OFF_QUOT, rows[k].q);
         rdc(IHD_OFF_REM, rows[k].r);
         rdc(IHD_OFF_STATUS, {30'h0, rows[k].b == '0, 1'b1});
      end
      // operands are snapshotted, so a late dividend write must not leak in
      wr(IHD_OFF_DIVIDEND, 32'd100);
      wr(IHD_OFF_DIVISOR, 32'd7);
      wr(IHD_OFF_DIVIDEND, 32'h0);
      rdc(IHD_OFF_QUOT, 32'h3);
      rdc(IHD_OFF_REM, 32'hffffffff);
      wait_done();
      rdc(IHD_OFF_QUOT, 32'he);
      rdc(IHD_OFF_REM, 32'h2);
      wr(IHD_OFF_DIVISOR, 32'h3);
      for (int i = 1; i <= 11; i++) begin
         @(posedge clk);
         bus_req <= '{addr: IHD_OFF_STATUS, wdata: '0, wr: 1'b0, rd: 1'b1};
         #1;
         if (i > 1) check(bus_rdata, {31'h0, i >= 10});
      end
      idle();
      wr(IHD_OFF_QUOT, 32'h12345678);
      rdc(IHD_OFF_QUOT, 32'h12345678);
      wr(IHD_OFF_IRQ_STAT, 32'h3);
      wr(IHD_OFF_DIVISOR, 32'h0);
      rdc(IHD_OFF_STATUS, 32'h3);
      rdc(IHD_OFF_IRQ_STAT, 32'h3);
      check({31'h0, irq}, 32'h0);
      wr(IHD_OFF_IRQ_MASK, 32'h2);
      idle();
      #1;
      check({31'h0, irq}, 32'h1);
      wr(IHD_OFF_IRQ_STAT, 32'h2);
      wr(IHD_OFF_STATUS, 32'h0);
      rdc(IHD_OFF_IRQ_STAT, 32'h1);
      check({31'h0, irq}, 32'h0);
      rdc(IHD_OFF_STATUS, 32'h3);
      rdc(IHD_OFF_QUOT, 32'h0);
      wr(IHD_OFF_DIVISOR, 32'h5);
      do_reset();
      for (int i = 0; i < 9; i++) begin
         rdc(ra[i], rx[i]);
      end
      give_verdict();
   end
endmodule

`default_nettype wire
